// >>> inc/svm_pkg.sv
package svm_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFS_PROTECT = 8'h00;
    localparam logic [7:0] OFS_CLKCFG = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_IRQEN = 8'h10;
    // ****************************************
    // Keys and reset values
    // ****************************************
    localparam logic [15:0] UNLOCK_KEY = 16'h0096;
    localparam logic [3:0] RESET_KEY = 4'ha;
    localparam logic [4:0] LEVEL_RST = 5'h1e;
    localparam logic DEBUG_RUN_ENABLE_RST = 1'b1;
    localparam logic [1:0] MODE_CONT = 2'h0;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int CLK_DEBUG_RUN_ENABLE_POS = 8;
    localparam int CLK_DIV_POS = 4;
    localparam int CLK_SRC_POS = 0;
    localparam int CTL_SRCEXT_POS = 15;
    localparam int CTL_CNT_POS = 13;
    localparam int CTL_LVL_POS = 8;
    localparam int CTL_KEY_POS = 4;
    localparam int CTL_PIN_POS = 3;
    localparam int CTL_MODE_POS = 1;
    localparam int CTL_EN_POS = 0;
    localparam int STS_RESULT_POS = 8;
    localparam int STS_FLAG_POS = 0;
    // ****************************************
    // Cycle counts
    // ****************************************
    localparam logic [8:0] IVL_128_LAST = 9'h07f;
    localparam logic [8:0] IVL_256_LAST = 9'h0ff;
    localparam logic [8:0] IVL_512_LAST = 9'h1ff;
    localparam logic [15:0] DIV_BASE = 16'h0010;
    localparam logic [2:0] DIV_MAX = 3'h5;
endpackage

// >>> logic/level_sync.sv
module level_sync #(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_q
);
    logic [WIDTH-1:0] meta_q;

    // ****************************************
    // Two flip-flops per bit
    // ****************************************
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                meta_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
            end else begin
                meta_q[i] <= async_in[i];
                sync_q[i] <= meta_q[i];
            end
        end
    end
endmodule

// >>> logic/monitor_clk_div.sv
module monitor_clk_div
    import svm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [3:0] src_tick,
    input wire logic [1:0] src_sel,
    input wire logic [2:0] div_sel,
    input wire logic run,
    output logic tick_q
);
    logic [8:0] cnt_q;
    logic [8:0] last;
    logic fast;
    logic src_on;

    assign fast = src_sel[0];
    assign src_on = src_tick[src_sel] && run;
    assign last = 9'((DIV_BASE << div_sel) - 16'h0001);

    // ****************************************
    // Prescaler
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 9'h000;
            tick_q <= 1'b0;
        end else begin
            tick_q <= 1'b0;
            if (src_on && fast) begin
                tick_q <= 1'b1;
            end else if (src_on && div_sel <= DIV_MAX) begin
                if (cnt_q >= last) begin
                    cnt_q <= 9'h000;
                    tick_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 9'h001;
                end
            end
        end
    end
endmodule

// >>> logic/supply_monitor.sv
// Notes on behaviour
// - Sleep-stop set for chosen source halts the monitor clock in sleep.
// - Debug-run at 0 suspends the monitor clock in debug mode.
// - Debug-run at 1 keeps the monitor clock running in debug mode.
// - Result reads 1 below threshold, 0 at or above it.
// - Mode 0 detects continuously, updating result on every comparison.
// - Continuous low raises reset if key is 0xa, else interrupt.
// - Modes 1 to 3 power up, detect once, power down per interval.
// - Intermittent mode acts only after the set consecutive low count.
// - Flag sets on continuous low or reached count; write 1 clears.
// - Interrupt request only while flag and enable are both set.
// - Flag stays set after voltage recovers until software clears it.
// - Reset comes with flag set; detector runs continuous during reset.
// - Monitor reset keeps the external sense pin routed to detector.
// - Reset releases when result returns 0; mode stays continuous afterwards.
// - Five-bit level field, 32 levels; core supply uses 28.
// - Source is core supply or external sense pin 0 only.
// - Mode codes: continuous, every 128, 256, 512 monitor clocks.
// - Count codes: once, twice, four, eight; ignored when continuous.
// - During monitor reset count, mode and irq enable are cleared.
// - Changing count, key, mode or clearing flag restarts sequencer.
module supply_monitor
    import svm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata_q,
    output logic pready_q,
    output logic pslverr_q,
    input wire logic [3:0] src_tick,
    input wire logic [3:0] osc_sleep_stop,
    input wire logic sleep_mode,
    input wire logic debug_mode,
    input wire logic comp_low_async,
    output logic comp_power_q,
    output logic comp_ext_q,
    output logic ext_route_q,
    output logic [4:0] level_q,
    output logic irq_q,
    output logic mon_reset_q
);
    typedef enum logic [1:0] {ST_OFF, ST_CONT, ST_WAIT, ST_SAMPLE} seq_e;

    logic unlocked_q;
    logic [1:0] src_q;
    logic [2:0] div_q;
    logic debug_run_enable_q;
    logic src_ext_q;
    logic [1:0] count_q;
    logic [3:0] key_q;
    logic pin_q;
    logic [1:0] mode_q;
    logic enable_q;
    logic result_q;
    logic flag_q;
    logic irq_en_q;
    seq_e state_q, state_d;
    logic [8:0] ivl_q;
    logic [2:0] warm_q;
    logic [3:0] cnt_q;
    logic [8:0] ivl_last;
    logic [31:0] rdata_d;
    logic tick;
    logic run;
    logic comp_low;
    logic wr, wr_ctl, wr_clr;
    logic sampling, event_w, reinit;

    // ****************************************
    // Clock gating and sub-blocks
    // ****************************************
    assign run = !(sleep_mode && osc_sleep_stop[src_q])
        && !(debug_mode && !debug_run_enable_q);

    monitor_clk_div u_div (
        .pclk(pclk),
        .presetn(presetn),
        .src_tick(src_tick),
        .src_sel(src_q),
        .div_sel(div_q),
        .run(run),
        .tick_q(tick)
    );

    level_sync #(.WIDTH(1)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(comp_low_async),
        .sync_q(comp_low)
    );

    // ****************************************
    // APB slave
    // ****************************************
    assign wr = psel && penable && pwrite && pready_q;
    assign wr_ctl = wr && paddr == OFS_CTRL && unlocked_q;
    assign wr_clr = wr && paddr == OFS_STATUS && pwdata[STS_FLAG_POS];

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (paddr == OFS_PROTECT) begin
            rdata_d[0] = unlocked_q;
        end else if (paddr == OFS_CLKCFG) begin
            rdata_d[CLK_DEBUG_RUN_ENABLE_POS] = debug_run_enable_q;
            rdata_d[CLK_DIV_POS +: 3] = div_q;
            rdata_d[CLK_SRC_POS +: 2] = src_q;
        end else if (paddr == OFS_CTRL) begin
            rdata_d[CTL_SRCEXT_POS] = src_ext_q;
            rdata_d[CTL_CNT_POS +: 2] = count_q;
            rdata_d[CTL_LVL_POS +: 5] = level_q;
            rdata_d[CTL_KEY_POS +: 4] = key_q;
            rdata_d[CTL_PIN_POS] = pin_q;
            rdata_d[CTL_MODE_POS +: 2] = mode_q;
            rdata_d[CTL_EN_POS] = enable_q;
        end else if (paddr == OFS_STATUS) begin
            rdata_d[STS_RESULT_POS] = result_q;
            rdata_d[STS_FLAG_POS] = flag_q;
        end else if (paddr == OFS_IRQEN) begin
            rdata_d[0] = irq_en_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel && !penable;
            if (psel && !penable) begin
                prdata_q <= rdata_d;
                pslverr_q <= paddr > OFS_IRQEN || paddr[1:0] != 2'h0;
            end
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlocked_q <= 1'b0;
        end else if (wr && paddr == OFS_PROTECT) begin
            unlocked_q <= pwdata[15:0] == UNLOCK_KEY;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_q <= 2'h0;
            div_q <= 3'h0;
            debug_run_enable_q <= DEBUG_RUN_ENABLE_RST;
        end else if (wr && paddr == OFS_CLKCFG && unlocked_q) begin
            src_q <= pwdata[CLK_SRC_POS +: 2];
            div_q <= pwdata[CLK_DIV_POS +: 3];
            debug_run_enable_q <= pwdata[CLK_DEBUG_RUN_ENABLE_POS];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_ext_q <= 1'b0;
            level_q <= LEVEL_RST;
            key_q <= 4'h0;
            pin_q <= 1'b0;
            enable_q <= 1'b0;
        end else if (wr_ctl) begin
            src_ext_q <= pwdata[CTL_SRCEXT_POS];
            level_q <= pwdata[CTL_LVL_POS +: 5];
            key_q <= pwdata[CTL_KEY_POS +: 4];
            pin_q <= pwdata[CTL_PIN_POS];
            enable_q <= pwdata[CTL_EN_POS];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 2'h0;
            mode_q <= MODE_CONT;
            irq_en_q <= 1'b0;
        end else if (mon_reset_q) begin
            count_q <= 2'h0;
            mode_q <= MODE_CONT;
            irq_en_q <= 1'b0;
        end else begin
            if (wr_ctl) begin
                mode_q <= pwdata[CTL_MODE_POS +: 2];
                if (pwdata[CTL_MODE_POS +: 2] != MODE_CONT) begin
                    count_q <= pwdata[CTL_CNT_POS +: 2];
                end
            end
            if (wr && paddr == OFS_IRQEN) begin
                irq_en_q <= pwdata[0];
            end
        end
    end

    // ****************************************
    // Detection sequencer
    // ****************************************
    assign reinit = enable_q && (wr_clr || (wr_ctl && (
        pwdata[CTL_CNT_POS +: 2] != count_q
        || pwdata[CTL_KEY_POS +: 4] != key_q
        || pwdata[CTL_MODE_POS +: 2] != mode_q)));
    assign sampling = tick && (&warm_q)
        && (state_q == ST_CONT || state_q == ST_SAMPLE);
    assign event_w = sampling && comp_low && (state_q == ST_CONT
        || cnt_q + 4'h1 >= (4'h1 << count_q));

    always_comb begin
        case (mode_q)
            2'h2: ivl_last = IVL_256_LAST;
            2'h3: ivl_last = IVL_512_LAST;
            default: ivl_last = IVL_128_LAST;
        endcase
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_OFF: begin
                if (enable_q) begin
                    state_d = mode_q == MODE_CONT ? ST_CONT : ST_WAIT;
                end
            end
            ST_CONT: begin
                if (mode_q != MODE_CONT) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (mode_q == MODE_CONT) begin
                    state_d = ST_CONT;
                end else if (tick && ivl_q >= ivl_last) begin
                    state_d = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (tick) begin
                    state_d = ST_WAIT;
                end
            end
            default: state_d = ST_OFF;
        endcase
        if (!enable_q) begin
            state_d = ST_OFF;
        end else if (reinit) begin
            state_d = ST_OFF;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_OFF;
            comp_power_q <= 1'b0;
            warm_q <= 3'h0;
        end else begin
            state_q <= state_d;
            comp_power_q <= state_d == ST_CONT || state_d == ST_SAMPLE;
            warm_q <= {warm_q[1:0], comp_power_q};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ivl_q <= 9'h000;
        end else if (state_q != ST_WAIT || reinit) begin
            ivl_q <= 9'h000;
        end else if (tick) begin
            ivl_q <= ivl_q + 9'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
        end else if (state_q == ST_OFF || state_q == ST_CONT || reinit) begin
            cnt_q <= 4'h0;
        end else if (sampling) begin
            cnt_q <= comp_low && !event_w ? cnt_q + 4'h1 : 4'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= 1'b0;
        end else if (sampling) begin
            result_q <= comp_low;
        end
    end

    // ****************************************
    // Flag, interrupt and reset
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
        end else if (event_w) begin
            flag_q <= 1'b1;
        end else if (wr_clr) begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
            mon_reset_q <= 1'b0;
        end else begin
            irq_q <= flag_q && irq_en_q && !mon_reset_q;
            if (event_w && key_q == RESET_KEY) begin
                mon_reset_q <= 1'b1;
            end else if (sampling && !comp_low) begin
                mon_reset_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comp_ext_q <= 1'b0;
            ext_route_q <= 1'b0;
        end else begin
            comp_ext_q <= src_ext_q;
            ext_route_q <= src_ext_q && !pin_q;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_low_seen;
        sampling && comp_low;
    endsequence

    sequence s_high_seen;
        sampling && !comp_low;
    endsequence

    AST_IRQ_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        irq_q |-> $past(flag_q) && $past(irq_en_q))
        else $error("irq without flag and enable");
    AST_FLAG_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
        flag_q && !wr_clr |=> flag_q)
        else $error("flag dropped without clear");
    AST_FLAG_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
        event_w |=> flag_q)
        else $error("flag not set on event");
    AST_CONT_RESET: assert property (@(posedge pclk) disable iff (!presetn)
        s_low_seen ##0 (state_q == ST_CONT && key_q == RESET_KEY)
        |=> mon_reset_q && flag_q)
        else $error("continuous low with key gave no reset");
    AST_NO_RESET_KEY: assert property (@(posedge pclk) disable iff (!presetn)
        !mon_reset_q && key_q != RESET_KEY |=> !mon_reset_q)
        else $error("reset without reset key");
    AST_RESET_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
        mon_reset_q |=> mode_q == MODE_CONT && count_q == 2'h0 && !irq_en_q)
        else $error("fields not cleared in monitor reset");
    AST_RESET_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
        mon_reset_q ##0 s_high_seen |=> !mon_reset_q && !result_q)
        else $error("reset held after high result");
    AST_DEBUG_STOP: assert property (@(posedge pclk) disable iff (!presetn)
        debug_mode && !debug_run_enable_q |=> !tick)
        else $error("monitor clock ran in debug");
    AST_SLEEP_STOP: assert property (@(posedge pclk) disable iff (!presetn)
        sleep_mode && osc_sleep_stop[src_q] |=> !tick)
        else $error("monitor clock ran in sleep");
    AST_RESULT: assert property (@(posedge pclk) disable iff (!presetn)
        sampling |=> result_q == $past(comp_low))
        else $error("result not loaded");
    AST_INTERVAL: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_SAMPLE && tick |=> state_q != ST_SAMPLE)
        else $error("intermittent sample longer than one tick");
endmodule

// >>> verification/comparator_front.sv
module comparator_front (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic comp_power_q,
    input wire logic [4:0] level_q,
    input wire logic [4:0] vin,
    output logic [3:0] src_tick,
    output logic comp_low_async
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div_q;
    // ****************************************
    // Clock sources, one pulse every 4 pclk
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end
    assign src_tick = {4{div_q == 2'h3}};
    // ****************************************
    // Comparator, junk while unpowered
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comp_low_async <= 1'b0;
        end else if (comp_power_q) begin
            comp_low_async <= (vin < level_q);
        end else begin
            comp_low_async <= ~comp_low_async;
        end
    end
endmodule

// >>> verification/supply_monitor_tb.sv
module supply_monitor_tb
    import svm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata_q, d;
    logic pready_q, pslverr_q, sleep_mode, debug_mode, e;
    logic [3:0] src_tick, osc_sleep_stop;
    logic comp_low_async, comp_power_q, comp_ext_q, ext_route_q;
    logic irq_q, mon_reset_q;
    logic [4:0] level_q, vin;
    int err_count = 0;
    int tests_run = 0;
    int n, c;
    supply_monitor u_supply_monitor (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
        .pslverr_q(pslverr_q), .src_tick(src_tick),
        .osc_sleep_stop(osc_sleep_stop), .sleep_mode(sleep_mode),
        .debug_mode(debug_mode), .comp_low_async(comp_low_async),
        .comp_power_q(comp_power_q), .comp_ext_q(comp_ext_q),
        .ext_route_q(ext_route_q), .level_q(level_q), .irq_q(irq_q),
        .mon_reset_q(mon_reset_q));
    comparator_front u_comparator_front (.pclk(pclk), .presetn(presetn),
        .comp_power_q(comp_power_q), .level_q(level_q), .vin(vin),
        .src_tick(src_tick), .comp_low_async(comp_low_async));
    always #4 pclk = ~pclk;
    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready_q !== 1'b1);
        rd = prdata_q;
        er = pslverr_q;
        check("pready", {31'h0, pready_q}, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, d, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input logic experr);
        apb(1'b0, a, 32'h0, d, e);
        check($sformatf("read %h", a), d, exp);
        check("pslverr", {31'h0, e}, {31'h0, experr});
    endtask
    task automatic wait_lvl(ref logic s, input logic v, input int lim,
                            input string nm);
        int k = 0;
        while (s !== v && k < lim) begin
            @(negedge pclk);
            k++;
        end
        check(nm, {31'h0, s}, {31'h0, v});
    endtask
    task automatic count_pwr(input int cyc, output int cnt);
        logic p;
        cnt = 0;
        p = comp_power_q;
        repeat (cyc) begin
            @(negedge pclk);
            if (comp_power_q === 1'b1 && p === 1'b0) cnt++;
            p = comp_power_q;
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ****************************************
    // Watchdog
    // ****************************************
    initial begin
        repeat (60000) @(posedge pclk);
        err_count++;
        finish_test();
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sleep_mode = 1'b0;
        debug_mode = 1'b0;
        osc_sleep_stop = 4'h0;
        vin = 5'h1f;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_CLKCFG, 32'h0000_0100, 1'b0);
        rd(OFS_CTRL, 32'h0000_1e00, 1'b0);
        rd(OFS_IRQEN, 32'h0, 1'b0);
        rd(8'h14, 32'h0, 1'b1);
        wr(OFS_CTRL, 32'h0000_0001);
        rd(OFS_CTRL, 32'h0000_1e00, 1'b0);
        wr(OFS_PROTECT, {16'h0, UNLOCK_KEY});
        wr(OFS_CLKCFG, 32'h0000_0101);
        // Continuous mode with interrupt
        wr(OFS_CTRL, 32'h0000_1000);
        wr(OFS_STATUS, 32'h1);
        wr(OFS_IRQEN, 32'h1);
        wr(OFS_CTRL, 32'h0000_1001);
        check("level", {27'h0, level_q}, 32'h10);
        vin <= 5'h10;
        repeat (40) @(posedge pclk);
        wr(OFS_STATUS, 32'h1);
        repeat (20) @(posedge pclk);
        rd(OFS_STATUS, 32'h0, 1'b0);
        wr(OFS_CTRL, 32'h0000_1101);
        repeat (20) @(posedge pclk);
        rd(OFS_STATUS, 32'h0000_0101, 1'b0);
        check("irq", {31'h0, irq_q}, 32'h1);
        check("mon_reset", {31'h0, mon_reset_q}, 32'h0);
        vin <= 5'h1f;
        repeat (20) @(posedge pclk);
        rd(OFS_STATUS, 32'h0000_0001, 1'b0);
        wr(OFS_IRQEN, 32'h0);
        repeat (2) @(posedge pclk);
        check("irq", {31'h0, irq_q}, 32'h0);
        wr(OFS_STATUS, 32'h1);
        rd(OFS_STATUS, 32'h0, 1'b0);
        // Intermittent intervals
        for (int m = 1; m <= 3; m++) begin
            wr(OFS_CTRL, (32'(m) << 1) | 32'h0000_1001);
            wait_lvl(comp_power_q, 1'b1, 3000, "power on");
            wait_lvl(comp_power_q, 1'b0, 40, "power off");
            c = 0;
            while (comp_power_q !== 1'b1 && c < 3000) begin
                @(negedge pclk);
                if (src_tick[1]) c++;
            end
            n = 64 << m;
            check("gap", 32'(c >= n - 3 && c <= n + 3), 32'h1);
        end
        // Consecutive counts
        vin <= 5'h00;
        for (int k = 0; k < 4; k++) begin
            wr(OFS_CTRL, (32'(k) << 13) | 32'h0000_1003);
            wr(OFS_STATUS, 32'h1);
            n = 0;
            repeat (9) begin
                wait_lvl(comp_power_q, 1'b1, 3000, "power on");
                wait_lvl(comp_power_q, 1'b0, 40, "power off");
                n++;
                repeat (12) @(posedge pclk);
                apb(1'b0, OFS_STATUS, 32'h0, d, e);
                if (d[STS_FLAG_POS] === 1'b1) break;
            end
            check("low count", 32'(n), 32'h1 << k);
        end
        // Clock stop in debug and sleep
        vin <= 5'h1f;
        wr(OFS_CLKCFG, 32'h0000_0001);
        debug_mode <= 1'b1;
        count_pwr(1200, c);
        check("debug stop", 32'(c), 32'h0);
        debug_mode <= 1'b0;
        count_pwr(1200, c);
        check("debug resume", 32'(c != 0), 32'h1);
        wr(OFS_CLKCFG, 32'h0000_0101);
        debug_mode <= 1'b1;
        count_pwr(1200, c);
        check("debug run", 32'(c != 0), 32'h1);
        debug_mode <= 1'b0;
        osc_sleep_stop <= 4'h2;
        sleep_mode <= 1'b1;
        count_pwr(1200, c);
        check("sleep stop", 32'(c), 32'h0);
        sleep_mode <= 1'b0;
        count_pwr(1200, c);
        check("sleep resume", 32'(c != 0), 32'h1);
        // Monitor reset
        wr(OFS_IRQEN, 32'h1);
        wr(OFS_STATUS, 32'h1);
        wr(OFS_CTRL, 32'h0000_b0a3);
        vin <= 5'h00;
        wait_lvl(mon_reset_q, 1'b1, 3000, "mon reset");
        rd(OFS_CTRL, 32'h0000_90a1, 1'b0);
        rd(OFS_IRQEN, 32'h0, 1'b0);
        rd(OFS_STATUS, 32'h0000_0101, 1'b0);
        check("ext route", {31'h0, ext_route_q}, 32'h1);
        check("ext source", {31'h0, comp_ext_q}, 32'h1);
        repeat (600) @(posedge pclk);
        check("powered", {31'h0, comp_power_q}, 32'h1);
        vin <= 5'h1f;
        wait_lvl(mon_reset_q, 1'b0, 100, "release");
        vin <= 5'h00;
        wait_lvl(mon_reset_q, 1'b1, 40, "cont reset");
        vin <= 5'h1f;
        wait_lvl(mon_reset_q, 1'b0, 100, "release");
        wr(OFS_CTRL, 32'h0000_1000);
        wait_lvl(comp_power_q, 1'b0, 10, "stopped");
        wr(OFS_PROTECT, 32'h0);
        wr(OFS_CTRL, 32'h0000_0001);
        rd(OFS_CTRL, 32'h0000_1000, 1'b0);
        finish_test();
    end
endmodule
